// ===== mas_isqrt.sv
// shared constants for the axis status readback, and a sequential integer square root
// assumes one clock, asynchronous active-high reset, start pulsed only while idle
`timescale 1ns/10ps
// ==========================================================================
// package
package mas_pkg;
  localparam int NAX = 8;                       // axes and analog outputs
  localparam int NVS = 4;                       // vector spaces
  localparam int DAC_W = 16;
  localparam int FE_W = 16;
  localparam int STEP_W = 32;
  localparam int DATA_W = 32;
  localparam int ACC_W = 34;                    // sum of eight 31-bit squares
  localparam int ROOT_W = 16;
  localparam int ROOT_STEPS = 16;
  localparam int DIV_STEPS = 34;
  // command opcodes
  localparam logic [2:0] OP_FOLLOW_ERR = 3'h0;
  localparam logic [2:0] OP_STEPS_GEN = 3'h1;
  localparam logic [2:0] OP_POSITION = 3'h2;
  localparam logic [2:0] OP_DAC_LIMIT = 3'h3;
  localparam logic [2:0] OP_MOVE_DONE = 3'h4;
  // destination codes
  localparam logic [7:0] DEST_DISCARD = 8'h00;
  localparam logic [7:0] DEST_HOST = 8'hFF;
  localparam logic [7:0] DEST_DIR_LO = 8'h01;
  localparam logic [7:0] DEST_DIR_HI = 8'h78;
  localparam logic [7:0] DEST_IND_LO = 8'h81;
  localparam logic [7:0] DEST_IND_HI = 8'hF8;
  // move-done word fields
  localparam int MD_USER_LSB = 8;
  localparam int MD_USER_W = 3;
  localparam int MD_PWRUP_BIT = 15;
  localparam int MD_W = 16;
  // move-complete criteria enable bits
  localparam int CR_PROFILE = 0;
  localparam int CR_STOPPED = 1;
  localparam int CR_INPOS = 2;
  localparam int CR_SETTLE = 3;
  localparam int CR_W = 4;
  localparam int SETTLE_W = 16;
  typedef enum logic [2:0] {ST_IDLE, ST_ACCUM, ST_DIVIDE, ST_ROOT, ST_REPLY} mas_state_e;
endpackage : mas_pkg

// ==========================================================================
// square root, one result bit per radicand pair, one pair per clock
module mas_isqrt
  import mas_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // request
  input wire logic i_start,
  input wire logic [31:0] i_radicand,
  // result
  output logic [ROOT_W-1:0] o_root_q,
  output logic o_done_q
);
  logic [31:0] rad_q, rad_d;
  logic [19:0] rem_q, rem_d;
  logic [4:0] cnt_q, cnt_d;
  logic busy_q, busy_d;
  logic [ROOT_W-1:0] root_d;
  logic done_d;
  logic [19:0] shifted;
  logic [19:0] trial;

  // next values: shift in two radicand bits, try subtracting 4*root+1
  always_comb begin
    rad_d = rad_q;
    rem_d = rem_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    root_d = o_root_q;
    done_d = 1'b0;
    shifted = {rem_q[17:0], rad_q[31:30]};
    trial = {2'h0, o_root_q, 2'h1};
    if (i_start && !busy_q) begin
      rad_d = i_radicand;
      rem_d = 20'h0;
      root_d = 16'h0;
      cnt_d = 5'h0;
      busy_d = 1'b1;
    end else if (busy_q) begin
      rad_d = {rad_q[29:0], 2'h0};
      if (shifted >= trial) begin
        rem_d = shifted - trial;
        root_d = {o_root_q[14:0], 1'b1};
      end else begin
        rem_d = shifted;
        root_d = {o_root_q[14:0], 1'b0};
      end
      cnt_d = cnt_q + 5'h1;
      if (cnt_q == 5'(ROOT_STEPS - 1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // registers
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rad_q <= 32'h0;
      rem_q <= 20'h0;
      cnt_q <= 5'h0;
      busy_q <= 1'b0;
      o_root_q <= 16'h0;
      o_done_q <= 1'b0;
    end else begin
      rad_q <= rad_d;
      rem_q <= rem_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      o_root_q <= root_d;
      o_done_q <= done_d;
    end
  end
endmodule : mas_isqrt

// ===== mas_readback.sv
// axis status readback: torque-limit flags, following error, move-done word, step counters
// assumes all inputs synchronous to i_mclk; i_sample_tick pulses once per control-loop sample
//
// What this block does
// [RULE_01] separate positive and negative limit flag per output
// [RULE_02] unmapped outputs always report both flags false
// [RULE_03] flag is one while output saturated there
// [RULE_04] active axis reports live detector state
// [RULE_05] following-error trip freezes both limit flags
// [RULE_06] start, stop or blend resumes live reporting
// [RULE_07] vector space error is rms of members
// [RULE_08] move-done bitmap, one bit per axis, eight
// [RULE_09] move-done word readable directly, outside command path
// [RULE_10] move-done from per-axis configurable criteria
// [RULE_11] host may see stale move-done after start
// [RULE_12] three user status bits in move-done word
// [RULE_13] power-up state shows cause code instead
// [RULE_14] open-loop stepper: steps equal position
// [RULE_15] closed-loop counts every emitted step pulse; a pulse in a position-reset cycle is not counted
// [RULE_16] position reset loads step counter value
// [RULE_17] destination code routes or discards read results
// [RULE_18] signed step counter follows step direction
// [RULE_19] limits and trip evaluated per sample
`timescale 1ns/10ps
module mas_readback
  import mas_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // control loop
  input wire logic i_sample_tick,
  input wire logic [NAX-1:0][DAC_W-1:0] i_dac_value,
  input wire logic [NAX-1:0] i_dac_mapped,
  input wire logic [DAC_W-1:0] i_torque_pos_lim,
  input wire logic [DAC_W-1:0] i_torque_neg_lim,
  input wire logic [NAX-1:0] i_fe_trip,
  input wire logic [NAX-1:0] i_reactivate,
  input wire logic [NAX-1:0][FE_W-1:0] i_follow_err,
  input wire logic [NVS-1:0][NAX-1:0] i_vs_members,
  // stepper outputs
  input wire logic [NAX-1:0] i_step_pulse,
  input wire logic [NAX-1:0] i_step_dir,
  input wire logic [NAX-1:0] i_closed_loop,
  input wire logic [NAX-1:0][STEP_W-1:0] i_fb_steps,
  input wire logic [NAX-1:0] i_pos_reset,
  input wire logic [STEP_W-1:0] i_reset_value,
  // move-complete criteria
  input wire logic [NAX-1:0][CR_W-1:0] i_crit_en,
  input wire logic [NAX-1:0] i_profile_done,
  input wire logic [NAX-1:0] i_running,
  input wire logic [NAX-1:0] i_in_position,
  input wire logic [SETTLE_W-1:0] i_settle_cycles,
  input wire logic [MD_USER_W-1:0] i_user_set,
  input wire logic [MD_USER_W-1:0] i_user_clr,
  input wire logic i_powerup,
  input wire logic [7:0] i_powerup_code,
  // command port
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd_op,
  input wire logic i_cmd_vs,
  input wire logic [2:0] i_cmd_sel,
  input wire logic [7:0] i_cmd_dest,
  output logic o_cmd_ready_q,
  // results
  output logic o_host_valid_q,
  output logic [DATA_W-1:0] o_host_data_q,
  output logic o_var_wr_q,
  output logic o_var_ind_q,
  output logic [6:0] o_var_idx_q,
  output logic [DATA_W-1:0] o_var_data_q,
  output logic o_route_err_q,
  // status
  output logic [NAX-1:0] o_lim_pos_q,
  output logic [NAX-1:0] o_lim_neg_q,
  output logic [MD_W-1:0] o_move_done_bitmap_q
);
  // ==========================================================================
  // torque limits and latch
  logic [NAX-1:0] det_pos, det_neg, latched_q, latched_d, lim_pos_d, lim_neg_d;

  // detectors are sampled with the trip so the latched pair belongs to the tripping sample
  always_comb begin
    latched_d = latched_q;
    lim_pos_d = o_lim_pos_q;
    lim_neg_d = o_lim_neg_q;
    for (int a = 0; a < NAX; a++) begin
      // [RULE_01] [RULE_03] saturation compare
      det_pos[a] = $signed(i_dac_value[a]) >= $signed(i_torque_pos_lim);
      det_neg[a] = $signed(i_dac_value[a]) <= $signed(i_torque_neg_lim);
      // [RULE_06] reactivation unlatches
      if (i_reactivate[a])
        latched_d[a] = 1'b0;
      // [RULE_19] sample-rate update
      if (i_sample_tick) begin
        // [RULE_04] live while not latched
        if (!latched_q[a] || i_reactivate[a]) begin
          lim_pos_d[a] = det_pos[a];
          lim_neg_d[a] = det_neg[a];
        end
        // [RULE_05] trip freezes flags, wins over reactivation
        if (i_fe_trip[a]) begin
          latched_d[a] = 1'b1;
          lim_pos_d[a] = det_pos[a];
          lim_neg_d[a] = det_neg[a];
        end
      end
      // [RULE_02] unmapped output has no limits
      if (!i_dac_mapped[a]) begin
        lim_pos_d[a] = 1'b0;
        lim_neg_d[a] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      latched_q <= '0;
      o_lim_pos_q <= '0;
      o_lim_neg_q <= '0;
    end else begin
      latched_q <= latched_d;
      o_lim_pos_q <= lim_pos_d;
      o_lim_neg_q <= lim_neg_d;
    end
  end

  // ==========================================================================
  // step counters
  logic [NAX-1:0][STEP_W-1:0] steps_q, steps_d;

  // a reset load in the same cycle as a pulse wins; the pulse is lost by design
  always_comb begin
    for (int a = 0; a < NAX; a++) begin
      steps_d[a] = steps_q[a];
      // [RULE_16] position reset load
      if (i_pos_reset[a])
        steps_d[a] = i_reset_value;
      // [RULE_15] [RULE_18] count each emitted pulse
      else if (i_step_pulse[a])
        steps_d[a] = i_step_dir[a] ? steps_q[a] + 32'h1 : steps_q[a] - 32'h1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset)
      steps_q <= '0;
    else
      steps_q <= steps_d;
  end

  // ==========================================================================
  // move-done word
  logic [NAX-1:0][SETTLE_W-1:0] settle_q, settle_d;
  logic [NAX-1:0] crit_met, axis_done;
  logic [MD_USER_W-1:0] user_q, user_d;
  logic [MD_W-1:0] md_d;

  always_comb begin
    for (int a = 0; a < NAX; a++) begin
      // [RULE_10] enabled criteria only
      crit_met[a] = (!i_crit_en[a][CR_PROFILE] || i_profile_done[a])
                  && (!i_crit_en[a][CR_STOPPED] || !i_running[a])
                  && (!i_crit_en[a][CR_INPOS] || i_in_position[a]);
      settle_d[a] = settle_q[a];
      if (!crit_met[a])
        settle_d[a] = '0;
      else if (settle_q[a] < i_settle_cycles)
        settle_d[a] = settle_q[a] + 16'h1;
      axis_done[a] = crit_met[a] && (!i_crit_en[a][CR_SETTLE] || settle_q[a] >= i_settle_cycles);
    end
    // [RULE_12] user bits, set wins over clear
    user_d = (user_q & ~i_user_clr) | i_user_set;
    md_d = '0;
    md_d[MD_USER_LSB +: MD_USER_W] = user_q;
    // [RULE_13] power-up cause replaces axis bits
    if (i_powerup) begin
      md_d[7:0] = i_powerup_code;
      md_d[MD_PWRUP_BIT] = 1'b1;
    end else begin
      // [RULE_08] one bit per axis
      md_d[NAX-1:0] = axis_done;
    end
  end

  // [RULE_09] direct port, independent of the command sequencer
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      settle_q <= '0;
      user_q <= '0;
      o_move_done_bitmap_q <= '0;
    end else begin
      settle_q <= settle_d;
      user_q <= user_d;
      o_move_done_bitmap_q <= md_d;
    end
  end

  // ==========================================================================
  // command sequencer
  mas_state_e state_q, state_d;
  logic [7:0] dest_q, dest_d;
  logic [NAX-1:0] mask_q, mask_d;
  logic [3:0] idx_q, idx_d, cnt_q, cnt_d;
  logic [5:0] bit_q, bit_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [4:0] rem_q, rem_d, rem_try;
  logic [DATA_W-1:0] res_q, res_d, rd_word;
  logic root_start, root_done;
  logic [ROOT_W-1:0] root_val;
  logic [31:0] sq;
  logic host_d, var_wr_d, var_ind_d, err_d, ready_d;
  logic [6:0] var_idx_d;
  logic [DATA_W-1:0] host_data_d, var_data_d;

  // immediate read word for single-cycle operations
  always_comb begin
    unique case (i_cmd_op)
      OP_STEPS_GEN: rd_word = steps_q[i_cmd_sel];
      // [RULE_14] open-loop position is the step count
      OP_POSITION: rd_word = i_closed_loop[i_cmd_sel] ? i_fb_steps[i_cmd_sel] : steps_q[i_cmd_sel];
      OP_DAC_LIMIT: rd_word = {16'h0, o_lim_neg_q, o_lim_pos_q};
      // [RULE_11] reflects only commands already executed
      OP_MOVE_DONE: rd_word = {16'h0, o_move_done_bitmap_q};
      default: rd_word = {{(DATA_W-FE_W){i_follow_err[i_cmd_sel][FE_W-1]}}, i_follow_err[i_cmd_sel]};
    endcase
  end

  // rms runs as square-accumulate, divide by member count, then root
  always_comb begin
    state_d = state_q;
    dest_d = dest_q;
    mask_d = mask_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    acc_d = acc_q;
    rem_d = rem_q;
    res_d = res_q;
    root_start = 1'b0;
    sq = 32'($signed(i_follow_err[idx_q[2:0]]) * $signed(i_follow_err[idx_q[2:0]]));
    rem_try = {rem_q[3:0], acc_q[ACC_W-1]};
    unique case (state_q)
      ST_IDLE: begin
        if (i_cmd_valid) begin
          dest_d = i_cmd_dest;
          res_d = rd_word;
          state_d = ST_REPLY;
          // [RULE_07] vector space needs rms
          if (i_cmd_op == OP_FOLLOW_ERR && i_cmd_vs) begin
            mask_d = i_vs_members[i_cmd_sel[1:0]];
            idx_d = 4'h0;
            cnt_d = 4'h0;
            acc_d = '0;
            state_d = ST_ACCUM;
          end
        end
      end
      ST_ACCUM: begin
        if (mask_q[idx_q[2:0]]) begin
          acc_d = acc_q + {2'h0, sq};
          cnt_d = cnt_q + 4'h1;
        end
        idx_d = idx_q + 4'h1;
        if (idx_q == 4'(NAX - 1)) begin
          bit_d = 6'h0;
          rem_d = 5'h0;
          state_d = ST_DIVIDE;
        end
      end
      ST_DIVIDE: begin
        if (cnt_q == 4'h0) begin
          res_d = '0;
          state_d = ST_REPLY;
        end else begin
          if (rem_try >= {1'b0, cnt_q}) begin
            rem_d = rem_try - {1'b0, cnt_q};
            acc_d = {acc_q[ACC_W-2:0], 1'b1};
          end else begin
            rem_d = rem_try;
            acc_d = {acc_q[ACC_W-2:0], 1'b0};
          end
          bit_d = bit_q + 6'h1;
          // the root starts a cycle later, once the last quotient bit sits in acc_q
          if (bit_q == 6'(DIV_STEPS - 1)) begin
            state_d = ST_ROOT;
          end
        end
      end
      ST_ROOT: begin
        // one start pulse only; a second one would rerun the root on stale data
        if (bit_q == 6'(DIV_STEPS)) begin
          root_start = 1'b1;
          bit_d = bit_q + 6'h1;
        end
        if (root_done) begin
          res_d = {16'h0, root_val};
          state_d = ST_REPLY;
        end
      end
      ST_REPLY: state_d = ST_IDLE;
    endcase
  end

  // [RULE_17] result routing by destination code
  always_comb begin
    host_d = 1'b0;
    var_wr_d = 1'b0;
    var_ind_d = o_var_ind_q;
    var_idx_d = o_var_idx_q;
    err_d = 1'b0;
    host_data_d = o_host_data_q;
    var_data_d = o_var_data_q;
    ready_d = (state_d == ST_IDLE);
    if (state_q == ST_REPLY) begin
      if (dest_q == DEST_HOST) begin
        host_d = 1'b1;
        host_data_d = res_q;
      end else if (dest_q >= DEST_DIR_LO && dest_q <= DEST_DIR_HI) begin
        var_wr_d = 1'b1;
        var_ind_d = 1'b0;
        var_idx_d = dest_q[6:0];
        var_data_d = res_q;
      end else if (dest_q >= DEST_IND_LO && dest_q <= DEST_IND_HI) begin
        var_wr_d = 1'b1;
        var_ind_d = 1'b1;
        var_idx_d = dest_q[6:0];
        var_data_d = res_q;
      end else if (dest_q != DEST_DISCARD) begin
        err_d = 1'b1;                    // out-of-range code, result dropped
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      dest_q <= 8'h0;
      mask_q <= '0;
      idx_q <= 4'h0;
      cnt_q <= 4'h0;
      bit_q <= 6'h0;
      acc_q <= '0;
      rem_q <= 5'h0;
      res_q <= '0;
      o_cmd_ready_q <= 1'b1;
      o_host_valid_q <= 1'b0;
      o_host_data_q <= '0;
      o_var_wr_q <= 1'b0;
      o_var_ind_q <= 1'b0;
      o_var_idx_q <= 7'h0;
      o_var_data_q <= '0;
      o_route_err_q <= 1'b0;
    end else begin
      state_q <= state_d;
      dest_q <= dest_d;
      mask_q <= mask_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      acc_q <= acc_d;
      rem_q <= rem_d;
      res_q <= res_d;
      o_cmd_ready_q <= ready_d;
      o_host_valid_q <= host_d;
      o_host_data_q <= host_data_d;
      o_var_wr_q <= var_wr_d;
      o_var_ind_q <= var_ind_d;
      o_var_idx_q <= var_idx_d;
      o_var_data_q <= var_data_d;
      o_route_err_q <= err_d;
    end
  end

  mas_isqrt mas_isqrt_i (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_start(root_start),
    .i_radicand(acc_q[31:0]),
    .o_root_q(root_val),
    .o_done_q(root_done)
  );

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  unmapped_quiet_a: assert property (((o_lim_pos_q | o_lim_neg_q) & ~$past(i_dac_mapped)) == '0) // [RULE_02]
    else $error("unmapped output shows a limit flag");
  for (genvar a = 0; a < NAX; a++) begin : g_chk
    live_limit_a: assert property (i_sample_tick && !latched_q[a] && i_dac_mapped[a] // [RULE_04]
        |=> o_lim_pos_q[a] == $past(det_pos[a]) && o_lim_neg_q[a] == $past(det_neg[a]))
      else $error("live limit flag does not follow detector");
    trip_capture_a: assert property (i_sample_tick && i_fe_trip[a] && i_dac_mapped[a] // [RULE_05]
        |=> latched_q[a] && o_lim_pos_q[a] == $past(det_pos[a]))
      else $error("trip did not capture limit flags");
    latch_hold_a: assert property (latched_q[a] && !i_reactivate[a] && i_dac_mapped[a] // [RULE_06]
        |=> $stable(o_lim_pos_q[a]) && $stable(o_lim_neg_q[a]) && latched_q[a])
      else $error("latched limit flag changed");
    step_count_a: assert property (i_step_pulse[a] && !i_pos_reset[a] // [RULE_18]
        |=> steps_q[a] == ($past(i_step_dir[a]) ? $past(steps_q[a]) + 32'h1 : $past(steps_q[a]) - 32'h1))
      else $error("step counter did not follow pulse");
    steps_load_a: assert property (i_pos_reset[a] |=> steps_q[a] == $past(i_reset_value)) // [RULE_16]
      else $error("position reset did not load counter");
  end
  powerup_code_a: assert property (i_powerup ##1 i_powerup // [RULE_13]
      |-> o_move_done_bitmap_q[7:0] == $past(i_powerup_code) && o_move_done_bitmap_q[MD_PWRUP_BIT])
    else $error("power-up code missing from move-done word");
  user_set_a: assert property (|i_user_set |=> ##1 (o_move_done_bitmap_q[MD_USER_LSB +: MD_USER_W] // [RULE_12]
      & $past(i_user_set, 2)) == $past(i_user_set, 2))
    else $error("user status set lost");
  host_route_a: assert property (state_q == ST_REPLY && dest_q == DEST_HOST // [RULE_17]
      |=> o_host_valid_q && !o_var_wr_q && o_host_data_q == $past(res_q))
    else $error("host result not delivered");
  discard_route_a: assert property (state_q == ST_REPLY && dest_q == DEST_DISCARD // [RULE_17]
      |=> !o_host_valid_q && !o_var_wr_q && !o_route_err_q)
    else $error("discarded result was delivered");
  rms_bound_a: assert property (o_cmd_ready_q && i_cmd_valid && i_cmd_op == OP_FOLLOW_ERR && i_cmd_vs // [RULE_07]
      |=> ##[1:70] state_q == ST_REPLY)
    else $error("vector space rms did not finish");

  rms_read_c: cover property (state_q == ST_ROOT ##[1:20] state_q == ST_REPLY);
  trip_latch_c: cover property (i_sample_tick && i_fe_trip[0] && det_pos[0] ##[1:50] i_reactivate[0]);
  indirect_wr_c: cover property (o_var_wr_q && o_var_ind_q);
  powerup_c: cover property (i_powerup ##1 !i_powerup);
endmodule : mas_readback

// ===== mas_host_model.sv
// host-side model that receives read results routed to it
// assumes result pulses last one i_mclk cycle
`timescale 1ns/10ps
// ==========================================================================
// host receiver
module mas_host_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // results from the block
  input wire logic i_host_valid,
  input wire logic [31:0] i_host_data,
  // seen by the bench
  output logic [7:0] o_reply_cnt_q,
  output logic [31:0] o_last_data_q
);
  // the host never stalls, so every reply pulse must be caught here
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_reply_cnt_q <= 8'h00;
      o_last_data_q <= 32'h0;
    end else if (i_host_valid) begin
      o_reply_cnt_q <= o_reply_cnt_q + 8'h01;
      o_last_data_q <= i_host_data;
    end
  end
endmodule : mas_host_model

// ===== test_motion_axis_status_readback.sv
// testbench for the axis status readback block
// assumes a 100 MHz clock; inputs change on the falling edge
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
// ==========================================================================
// bench top
module test_motion_axis_status_readback;
  import mas_pkg::*;
  logic i_mclk = 1'b0, i_reset = 1'b1, i_sample_tick = 1'b0, i_powerup = 1'b0, i_cmd_valid = 1'b0, i_cmd_vs = 1'b0;
  logic [NAX-1:0][DAC_W-1:0] i_dac_value = '0;
  logic [NAX-1:0][FE_W-1:0] i_follow_err = '0;
  logic [NAX-1:0][STEP_W-1:0] i_fb_steps = '0;
  logic [NVS-1:0][NAX-1:0] i_vs_members = '0;
  logic [NAX-1:0][CR_W-1:0] i_crit_en = {NAX{4'h1}};
  logic [NAX-1:0] i_dac_mapped = 8'hFB, i_fe_trip = '0, i_reactivate = '0, i_step_pulse = '0, i_step_dir = '0;
  logic [NAX-1:0] i_closed_loop = '0, i_pos_reset = '0, i_profile_done = '0, i_running = '0, i_in_position = '0;
  logic [DAC_W-1:0] i_torque_pos_lim = 16'h7000, i_torque_neg_lim = 16'h9000;
  logic [STEP_W-1:0] i_reset_value = '0;
  logic [SETTLE_W-1:0] i_settle_cycles = 16'h0005;
  logic [MD_USER_W-1:0] i_user_set = '0, i_user_clr = '0;
  logic [7:0] i_powerup_code = 8'h5A, i_cmd_dest = 8'hFF, reply_cnt, cnt0;
  logic [2:0] i_cmd_op = '0, i_cmd_sel = '0;
  logic o_cmd_ready_q, o_host_valid_q, o_var_wr_q, o_var_ind_q, o_route_err_q, g_host, g_var, g_err, g_ind;
  logic [6:0] o_var_idx_q, g_idx;
  logic [DATA_W-1:0] o_host_data_q, o_var_data_q, g_data, last_data;
  logic [NAX-1:0] o_lim_pos_q, o_lim_neg_q;
  logic [MD_W-1:0] o_move_done_bitmap_q;
  int err_total = 0, n_tests = 0;
  logic [7:0] dests [4] = '{8'h01, 8'h78, 8'h81, 8'hF8};

  // 100 MHz clock
  always #5 i_mclk = ~i_mclk;

  mas_readback mas_readback_i (.i_mclk, .i_reset, .i_sample_tick, .i_dac_value, .i_dac_mapped, .i_torque_pos_lim,
    .i_torque_neg_lim, .i_fe_trip, .i_reactivate, .i_follow_err, .i_vs_members, .i_step_pulse, .i_step_dir,
    .i_closed_loop, .i_fb_steps, .i_pos_reset, .i_reset_value, .i_crit_en, .i_profile_done, .i_running,
    .i_in_position, .i_settle_cycles, .i_user_set, .i_user_clr, .i_powerup, .i_powerup_code, .i_cmd_valid,
    .i_cmd_op, .i_cmd_vs, .i_cmd_sel, .i_cmd_dest, .o_cmd_ready_q, .o_host_valid_q, .o_host_data_q, .o_var_wr_q,
    .o_var_ind_q, .o_var_idx_q, .o_var_data_q, .o_route_err_q, .o_lim_pos_q, .o_lim_neg_q, .o_move_done_bitmap_q);
  mas_host_model mas_host_model_i (.i_mclk, .i_reset, .i_host_valid(o_host_valid_q), .i_host_data(o_host_data_q),
    .o_reply_cnt_q(reply_cnt), .o_last_data_q(last_data));

  // ==========================================================================
  // shared drivers
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // one sample tick, flags land on the edge it is taken
  task automatic tick(input logic [7:0] trip);
    i_fe_trip = trip;
    i_sample_tick = 1'b1;
    @(negedge i_mclk);
    i_sample_tick = 1'b0;
    i_fe_trip = '0;
    @(negedge i_mclk);
  endtask : tick

  // issue one read and collect whichever result pulse comes back, bounded wait
  task automatic cmd(input logic [2:0] op, input logic vs, input logic [2:0] sel, input logic [7:0] dest);
    int n;
    n = 0;
    while (o_cmd_ready_q !== 1'b1 && n < 100) begin
      @(negedge i_mclk);
      n++;
    end
    {i_cmd_op, i_cmd_vs, i_cmd_sel, i_cmd_dest, i_cmd_valid} = {op, vs, sel, dest, 1'b1};
    @(negedge i_mclk);
    i_cmd_valid = 1'b0;
    {g_host, g_var, g_err} = 3'h0;
    for (n = 0; n < 80 && !(g_host | g_var | g_err); n++) begin
      {g_host, g_var, g_err, g_ind, g_idx} = {o_host_valid_q, o_var_wr_q, o_route_err_q, o_var_ind_q, o_var_idx_q};
      g_data = o_var_wr_q ? o_var_data_q : o_host_data_q;
      @(negedge i_mclk);
    end
  endtask : cmd

  task automatic step(input int a, input logic dir, input int cnt);
    repeat (cnt) begin
      i_step_dir[a] = dir;
      i_step_pulse[a] = 1'b1;
      @(negedge i_mclk);
      i_step_pulse[a] = 1'b0;
      @(negedge i_mclk);
    end
  endtask : step

  // ==========================================================================
  // scenarios
  task automatic t_limits();
    {i_dac_value[2], i_dac_value[1], i_dac_value[0]} = {16'h7FFF, 16'h9000, 16'h7000};
    tick(8'h00);
    `CHK(o_lim_pos_q[2:0], 3'h1)
    `CHK(o_lim_neg_q[2:0], 3'h2)
    `CHK({o_lim_pos_q[2], o_lim_neg_q[2]}, 2'h0)
    tick(8'h01);
    {i_dac_value[1], i_dac_value[0]} = '0;
    tick(8'h00);
    `CHK(o_lim_pos_q[0], 1'b1)
    `CHK(o_lim_neg_q[1], 1'b0)
    cmd(OP_DAC_LIMIT, 1'b0, 3'h0, DEST_HOST);
    `CHK({g_host, g_data}, {1'b1, 32'h1})
    i_reactivate[0] = 1'b1;
    @(negedge i_mclk);
    i_reactivate[0] = 1'b0;
    tick(8'h00);
    `CHK(o_lim_pos_q[0], 1'b0)
  endtask : t_limits

  task automatic t_route();
    i_follow_err[3] = 16'hFFF0;
    cmd(OP_FOLLOW_ERR, 1'b0, 3'h3, DEST_HOST);
    `CHK(g_data, 32'hFFFFFFF0)
    `CHK(last_data, 32'hFFFFFFF0)
    {i_follow_err[1], i_follow_err[0], i_vs_members[1]} = {16'hFFFB, 16'h0005, 8'h03};
    cmd(OP_FOLLOW_ERR, 1'b1, 3'h1, DEST_HOST);
    `CHK(g_data, 32'h5)
    foreach (dests[k]) begin
      cmd(OP_FOLLOW_ERR, 1'b0, 3'h3, dests[k]);
      `CHK({g_var, g_ind, g_idx, g_data}, {1'b1, dests[k], 32'hFFFFFFF0})
    end
    cnt0 = reply_cnt;
    cmd(OP_FOLLOW_ERR, 1'b0, 3'h3, DEST_DISCARD);
    `CHK({g_host, g_var, g_err, reply_cnt}, {3'h0, cnt0})
    cmd(OP_FOLLOW_ERR, 1'b0, 3'h3, 8'h79);
    `CHK({g_host, g_var, g_err}, 3'h1)
  endtask : t_route

  task automatic t_steps();
    {i_reset_value, i_pos_reset[4]} = {32'd100, 1'b1};
    @(negedge i_mclk);
    i_pos_reset[4] = 1'b0;
    step(4, 1'b1, 3);
    step(4, 1'b0, 1);
    cmd(OP_STEPS_GEN, 1'b0, 3'h4, DEST_HOST);
    `CHK(g_data, 32'd102)
    cmd(OP_POSITION, 1'b0, 3'h4, DEST_HOST);
    `CHK(g_data, 32'd102)
    {i_closed_loop[5], i_fb_steps[5], i_reset_value, i_pos_reset[5]} = {1'b1, 32'd100, 32'd0, 1'b1};
    @(negedge i_mclk);
    i_pos_reset[5] = 1'b0;
    step(5, 1'b1, 110);
    cmd(OP_STEPS_GEN, 1'b0, 3'h5, DEST_HOST);
    `CHK(g_data, 32'd110)
    i_fb_steps[5] = 32'd50;
    step(5, 1'b0, 50);
    cmd(OP_STEPS_GEN, 1'b0, 3'h5, DEST_HOST);
    `CHK(g_data, 32'd60)
    cmd(OP_POSITION, 1'b0, 3'h5, DEST_HOST);
    `CHK(g_data, 32'd50)
  endtask : t_steps

  task automatic t_done();
    {i_crit_en[3], i_crit_en[2], i_crit_en[1]} = {4'h4, 4'h8, 4'h2};
    {i_profile_done[0], i_running[1], i_in_position[3]} = 3'h7;
    repeat (2) @(negedge i_mclk);
    `CHK(o_move_done_bitmap_q[7:0], 8'h09)
    i_running[1] = 1'b0;
    repeat (10) @(negedge i_mclk);
    `CHK(o_move_done_bitmap_q[7:0], 8'h0F)
    i_user_set = 3'h2;
    @(negedge i_mclk);
    i_user_set = 3'h0;
    @(negedge i_mclk);
    `CHK(o_move_done_bitmap_q[10:8], 3'h2)
    cmd(OP_MOVE_DONE, 1'b0, 3'h0, DEST_HOST);
    `CHK(g_data, 32'h020F)
    i_user_clr = 3'h2;
    @(negedge i_mclk);
    i_user_clr = 3'h0;
    i_powerup = 1'b1;
    repeat (2) @(negedge i_mclk);
    `CHK(o_move_done_bitmap_q[10:8], 3'h0)
    `CHK({o_move_done_bitmap_q[15], o_move_done_bitmap_q[7:0]}, 9'h15A)
    i_powerup = 1'b0;
    repeat (2) @(negedge i_mclk);
    `CHK(o_move_done_bitmap_q, 16'h000F)
  endtask : t_done

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge i_mclk);
    `CHK({o_cmd_ready_q, o_lim_pos_q, o_host_valid_q}, 10'h200)
    @(negedge i_mclk);
    i_reset = 1'b0;
    t_limits();
    t_route();
    t_steps();
    t_done();
    end_sim();
  end

  // the whole run needs about 600 cycles, so 20000 means a hang
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule : test_motion_axis_status_readback
